// *** hw/ixe_exec.sv ***
// exec unit for inc/dec/complement, interrupt mask and carry branch
//
// Overview of operation
// - subtract-two writes destination minus two
// - subtract-two zero only when destination was two
// - subtract-two carry clear for zero or one
// - subtract-two overflow for 8001h/8000h or 81h/80h
// - mask op ANDs flag word with fff7h
// - mask op changes only interrupt enable bit
// - unmask op ORs 0008h, other bits kept
// - next instruction runs before pending interrupt
// - add-one writes plus one, mode bits kept
// - add-one zero only from ffffh or ffh
// - add-one carry only from ffffh or ffh
// - add-one overflow only from 7fffh or 7fh
// - add-two writes plus two, mode bits kept
// - add-two zero only from fffeh or feh
// - add-two carry from top two values
// - add-two overflow from 7ffeh/7fffh or 7eh/7fh
// - complement inverts every destination bit
// - complement carry is inverse of zero
// - complement overflow when original was negative
// - carry branch adds twice signed offset
// - unsigned higher-or-same is the carry branch
// - subtract-one carry clear only from zero
// - subtract-one overflow only from 8000h or 80h
//
// The placing of the registers and the address-and-strobe port were left to the implementer.
`include "ixe_cfg.svh"

module ixe_exec
    import ixe_pkg::*;
#(
    parameter int OFFSET_W = 10
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // register port
    input wire ixe_bus_s busReq,
    output logic [15:0] busRdata,
    // interrupt request from the controller
    input wire logic irqReq,
    output logic irqGrant
);

    // offset must fit beside its doubling inside a word
    initial begin
        if (OFFSET_W < 1 || OFFSET_W > 15) begin
            $error("OFFSET_W out of range");
        end
    end

    // arithmetic for every data op in one place
    function automatic ixe_alu_s aluCalc(
        input ixe_op_e op,
        input logic isByte,
        input logic [15:0] d
    );
        ixe_alu_s o;
        logic [16:0] sum;
        logic [15:0] k;
        logic [15:0] m;
        logic isSub;
        logic sd;
        logic sr;
        o = '0;
        m = isByte ? 16'h00ff : 16'hffff;
        k = (op == OP_SUB1 || op == OP_ADD1) ? 16'h0001 : 16'h0002;
        isSub = (op == OP_SUB1 || op == OP_SUB2);
        // subtract as add of ones complement plus one: carry = no borrow
        if (op == OP_INV) begin
            sum = {1'b0, d ^ m};
        end else if (isSub) begin
            sum = {1'b0, d & m} + {1'b0, ~k & m} + 17'h00001;
        end else begin
            sum = {1'b0, d & m} + {1'b0, k};
        end
        o.res = sum[15:0] & m;
        sd = isByte ? d[7] : d[15];
        sr = isByte ? o.res[7] : o.res[15];
        o.n = sr;
        o.z = (o.res == 16'h0000);
        // carry out sits one above the operand's top bit
        if (op == OP_INV) begin
            o.c = ~o.z;
        end else begin
            o.c = isByte ? sum[8] : sum[16];
        end
        // overflow: sign flips the wrong way for the direction
        if (op == OP_INV) begin
            o.v = sd;
        end else if (isSub) begin
            o.v = sd & ~sr;
        end else begin
            o.v = ~sd & sr;
        end
        return o;
    endfunction

    // doubled, sign-extended branch step
    function automatic logic [15:0] branchStep(
        input logic [OFFSET_W-1:0] off
    );
        logic signed [15:0] s;
        s = 16'(signed'(off));
        return {s[14:0], 1'b0};
    endfunction

    // register decode used by several processes
    function automatic logic hit(input ixe_bus_s b, input logic [3:0] a);
        return b.addr == a;
    endfunction

    ixe_state_e state; // sequencer
    ixe_state_e next_state;
    ixe_op_e cmdOp; // latched operation
    logic cmdByte; // latched byte form
    logic [15:0] operand; // destination operand
    logic [OFFSET_W-1:0] offset; // branch offset field
    logic [15:0] pc; // program counter
    logic [15:0] flagWord; // flag word
    logic gieLate; // enable as the controller sees it
    logic shadow; // one-instruction hold after unmask
    ixe_alu_s alu; // alu answer for the latched op
    logic execNow; // execute cycle
    logic isData; // latched op writes the operand
    logic cmdWr; // accepted command write
    logic [15:0] opMask; // byte or word mask
    logic [15:0] next_flags;

    assign execNow = (state == ST_EXEC);
    assign opMask = cmdByte ? 16'h00ff : 16'hffff;
    assign isData = (cmdOp == OP_SUB1) || (cmdOp == OP_SUB2) ||
                    (cmdOp == OP_ADD1) || (cmdOp == OP_ADD2) ||
                    (cmdOp == OP_INV);
    // a command write while busy is dropped; status shows busy
    assign cmdWr = busReq.wr && hit(busReq, `IXE_OFS_CMD) &&
                   (state == ST_IDLE);
    assign alu = aluCalc(cmdOp, cmdByte, operand);

    // sequencer: one execute cycle per accepted command
    always_comb begin
        next_state = state;
        unique case (state)
            ST_IDLE: begin
                if (cmdWr) begin
                    next_state = ST_EXEC;
                end
            end
            ST_EXEC: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // state register
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // command latch; unknown codes execute as no operation
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cmdOp <= OP_NONE;
            cmdByte <= 1'b0;
        end else if (cmdWr) begin
            cmdOp <= ixe_op_e'(busReq.wdata[`IXE_CMD_OP_LSB +: 4]);
            cmdByte <= busReq.wdata[`IXE_CMD_BYTE];
        end
    end

    // operand: execute result wins over a software write
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            operand <= `IXE_OPERAND_RST;
        end else if (execNow && isData) begin
            operand <= alu.res;
        end else if (busReq.wr && hit(busReq, `IXE_OFS_OPERAND)) begin
            operand <= busReq.wdata;
        end
    end

    // branch offset field, written by software only
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            offset <= '0;
        end else if (busReq.wr && hit(busReq, `IXE_OFS_OFFSET)) begin
            offset <= busReq.wdata[OFFSET_W-1:0];
        end
    end

    // program counter: taken branch only, fall-through leaves it
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pc <= `IXE_PC_RST;
        end else if (execNow && cmdOp == OP_BRC) begin
            if (flagWord[`IXE_BIT_C]) begin
                pc <= pc + branchStep(offset);
            end
        end else if (busReq.wr && hit(busReq, `IXE_OFS_PC)) begin
            pc <= busReq.wdata;
        end
    end

    // next flag word: data ops set arithmetic bits only, mask ops only the enable bit
    always_comb begin
        next_flags = flagWord;
        if (isData) begin
            next_flags = flagWord & ~`IXE_ARITH_MASK;
            next_flags[`IXE_BIT_N] = alu.n;
            next_flags[`IXE_BIT_Z] = alu.z;
            next_flags[`IXE_BIT_C] = alu.c;
            next_flags[`IXE_BIT_V] = alu.v;
        end else if (cmdOp == OP_MASK) begin
            next_flags = flagWord & `IXE_GIE_CLR;
        end else if (cmdOp == OP_UNMASK) begin
            next_flags = flagWord | `IXE_GIE_SET;
        end
    end

    // flag word register; the branch leaves it untouched
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            flagWord <= `IXE_FLAGS_RST;
        end else if (execNow) begin
            flagWord <= next_flags;
        end else if (busReq.wr && hit(busReq, `IXE_OFS_FLAGS)) begin
            flagWord <= busReq.wdata;
        end
    end

    // enable reaches the controller a cycle late, which is why
    // software puts a spare instruction after the mask op
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            gieLate <= 1'b0;
        end else begin
            gieLate <= flagWord[`IXE_BIT_GIE];
        end
    end

    // hold after unmask until the following command has run
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            shadow <= 1'b0;
        end else if (execNow) begin
            shadow <= (cmdOp == OP_UNMASK);
        end
    end

    // grant only between commands, never inside the hold
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            irqGrant <= 1'b0;
        end else begin
            irqGrant <= irqReq && gieLate && !shadow &&
                        (state == ST_IDLE) && !cmdWr;
        end
    end

    // read data one cycle after the strobe, zero otherwise
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            busRdata <= 16'h0000;
        end else if (busReq.rd) begin
            unique case (busReq.addr)
                `IXE_OFS_CMD: busRdata <= {7'h00, cmdByte, 4'h0, cmdOp};
                `IXE_OFS_OPERAND: busRdata <= operand;
                `IXE_OFS_OFFSET: busRdata <= 16'(offset);
                `IXE_OFS_PC: busRdata <= pc;
                `IXE_OFS_FLAGS: busRdata <= flagWord;
                `IXE_OFS_STATUS: begin
                    busRdata <= {13'h0000, gieLate, shadow, execNow};
                end
                // unmapped offsets read as zero
                default: busRdata <= 16'h0000;
            endcase
        end else begin
            busRdata <= 16'h0000;
        end
    end

    // ---- checks ----
    // the snapshot of the operand seen by the execute cycle
    logic [15:0] preVal;
    assign preVal = operand & opMask;

    sequence s_execOp(ixe_op_e o);
        execNow && cmdOp == o;
    endsequence

    sequence s_holdQuiet;
        !irqGrant ##1 !irqGrant;
    endsequence

    a_sub2_value: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        s_execOp(OP_SUB2) |=>
            operand == (16'($past(preVal) - 16'h0002) & $past(opMask)))
        else $error("subtract-two result wrong");

    a_sub2_zc: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        s_execOp(OP_SUB2) |=>
            flagWord[`IXE_BIT_Z] == ($past(preVal) == 16'h0002) &&
            flagWord[`IXE_BIT_C] == ($past(preVal) > 16'h0001))
        else $error("subtract-two zero or carry wrong");

    a_sub2_ovf: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        s_execOp(OP_SUB2) |=> flagWord[`IXE_BIT_V] ==
            ($past(preVal) == ($past(opMask) >> 1) + 16'h0001 ||
             $past(preVal) == ($past(opMask) >> 1) + 16'h0002))
        else $error("subtract-two overflow wrong");

    a_mask_gie: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        s_execOp(OP_MASK) |=>
            flagWord == ($past(flagWord) & 16'hfff7) ##1 !gieLate)
        else $error("mask op flag word wrong");

    a_unmask_hold: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        s_execOp(OP_UNMASK) |=>
            flagWord == ($past(flagWord) | 16'h0008) and s_holdQuiet)
        else $error("unmask op wrong or interrupt taken early");

    a_add1_flags: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        s_execOp(OP_ADD1) |=>
            flagWord[`IXE_BIT_C] == ($past(preVal) == $past(opMask)) &&
            flagWord[`IXE_BIT_Z] == ($past(preVal) == $past(opMask)) &&
            flagWord[`IXE_BIT_V] ==
                ($past(preVal) == ($past(opMask) >> 1)))
        else $error("add-one flags wrong");

    a_add2_flags: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        s_execOp(OP_ADD2) |=>
            flagWord[`IXE_BIT_C] ==
                ($past(preVal) >= $past(opMask) - 16'h0001) &&
            flagWord[`IXE_BIT_Z] ==
                ($past(preVal) == $past(opMask) - 16'h0001))
        else $error("add-two flags wrong");

    a_inv_flags: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        s_execOp(OP_INV) |=>
            operand == ($past(preVal) ^ $past(opMask)) &&
            flagWord[`IXE_BIT_C] == (operand != 16'h0000) &&
            flagWord[`IXE_BIT_V] == $past(preVal[15] | preVal[7] &
                                          cmdByte))
        else $error("complement result or flags wrong");

    a_branch_pc: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        s_execOp(OP_BRC) |=> flagWord == $past(flagWord) &&
            pc == ($past(flagWord[`IXE_BIT_C]) ?
                   16'($past(pc) + branchStep($past(offset))) :
                   $past(pc)))
        else $error("carry branch wrong");

    a_sub1_flags: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        s_execOp(OP_SUB1) |=>
            flagWord[`IXE_BIT_C] == ($past(preVal) != 16'h0000) &&
            flagWord[`IXE_BIT_V] ==
                ($past(preVal) == ($past(opMask) >> 1) + 16'h0001))
        else $error("subtract-one flags wrong");

    a_mode_kept: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        execNow && isData |=>
            flagWord[`IXE_BIT_GIE] == $past(flagWord[`IXE_BIT_GIE]) &&
            flagWord[5:4] == $past(flagWord[5:4]) &&
            flagWord[`IXE_BIT_N] ==
                (cmdByte ? operand[7] : operand[15]))
        else $error("mode bits or negative flag wrong");

endmodule

// *** shared/ixe_cfg.svh ***
// offsets, field positions, reset values and constants of the exec unit
`ifndef IXE_CFG_SVH
`define IXE_CFG_SVH
// register offsets (word index on the plain port)
`define IXE_OFS_CMD 4'h0
`define IXE_OFS_OPERAND 4'h1
`define IXE_OFS_OFFSET 4'h2
`define IXE_OFS_PC 4'h3
`define IXE_OFS_FLAGS 4'h4
`define IXE_OFS_STATUS 4'h5
// command register fields
`define IXE_CMD_OP_LSB 0
`define IXE_CMD_BYTE 8
// flag word bit positions
`define IXE_BIT_C 0
`define IXE_BIT_Z 1
`define IXE_BIT_N 2
`define IXE_BIT_GIE 3
`define IXE_BIT_CORE_HALT 4
`define IXE_BIT_OSC_HALT 5
`define IXE_BIT_V 8
// flag word constants
`define IXE_GIE_SET 16'h0008
`define IXE_GIE_CLR 16'hfff7
`define IXE_ARITH_MASK 16'h0107
// reset values
`define IXE_FLAGS_RST 16'h0000
`define IXE_PC_RST 16'h0000
`define IXE_OPERAND_RST 16'h0000
`endif

// *** shared/ixe_pkg.sv ***
// types shared by the exec unit
package ixe_pkg;
    // operation codes written into the command register
    typedef enum logic [3:0] {
        OP_NONE = 4'h0,
        OP_SUB1 = 4'h1,
        OP_SUB2 = 4'h2,
        OP_ADD1 = 4'h3,
        OP_ADD2 = 4'h4,
        OP_INV = 4'h5,
        OP_MASK = 4'h6,
        OP_UNMASK = 4'h7,
        OP_BRC = 4'h8
    } ixe_op_e;
    // sequencer states, one-hot
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_EXEC = 2'b10
    } ixe_state_e;
    // register port request
    typedef struct packed {
        logic [3:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } ixe_bus_s;
    // alu answer
    typedef struct packed {
        logic [15:0] res;
        logic n;
        logic z;
        logic c;
        logic v;
    } ixe_alu_s;
endpackage

// *** tb/tb_ixe_exec.sv ***
// self-checking bench for the exec unit, driven over the register port
`include "ixe_cfg.svh"
module tb_ixe_exec
    import ixe_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // clock and reset
    logic core_clk;
    logic sys_rst;
    // register port and interrupt handshake
    ixe_bus_s busReq;
    logic [15:0] busRdata;
    logic irqReq;
    logic irqGrant;
    // score keeping
    int num_errors;
    int checks;

    // device under test, default offset width
    ixe_exec #(.OFFSET_W(10)) i_ixe_exec (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .busReq(busReq),
        .busRdata(busRdata),
        .irqReq(irqReq),
        .irqGrant(irqGrant)
    );

    // 50 mhz clock
    always #10 core_clk = ~core_clk;

    // verdict and end of run, also reached by an expired wait
    task complete_run;
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // single compare for every 16-bit result
    task chk(input string what, input logic [15:0] exp,
             input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one-cycle write; the release edge leaves a gap before the next one
    task wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge core_clk);
        busReq <= {a, d, 1'b1, 1'b0};
        @(posedge core_clk);
        busReq <= '0;
    endtask

    // one-cycle read, data looked at only in the following cycle
    task rdchk(input string what, input logic [3:0] a,
               input logic [15:0] exp);
        @(posedge core_clk);
        busReq <= {a, 16'h0000, 1'b0, 1'b1};
        @(posedge core_clk);
        busReq <= '0;
        #1;
        chk(what, exp, busRdata);
    endtask

    // command word: op in low nibble, byte mode in bit 8
    task cmd(input ixe_op_e op, input logic byt);
        wr(`IXE_OFS_CMD, {7'h00, byt, 4'h0, op});
    endtask

    // arithmetic op from a flag word with every defined bit set (013fh);
    // mode bits must survive, arithmetic bits are rebuilt
    task run_alu(input ixe_op_e op, input logic byt, input logic [15:0] din,
                 input logic [15:0] res, input logic [15:0] ar);
        wr(`IXE_OFS_OPERAND, din);
        wr(`IXE_OFS_FLAGS, 16'h013f);
        cmd(op, byt);
        rdchk("operand", `IXE_OFS_OPERAND, res);
        rdchk("flags", `IXE_OFS_FLAGS, 16'h0038 | ar);
    endtask

    // carry branch from pc 1000h with a given offset
    task run_br(input logic c, input logic [9:0] off,
                input logic [15:0] pcExp);
        wr(`IXE_OFS_PC, 16'h1000);
        wr(`IXE_OFS_OFFSET, {6'h00, off});
        wr(`IXE_OFS_FLAGS, 16'h0136 | {15'h0000, c});
        cmd(OP_BRC, 1'b0);
        rdchk("pc", `IXE_OFS_PC, pcExp);
        rdchk("flags", `IXE_OFS_FLAGS, 16'h0136 | {15'h0000, c});
    endtask

    // grant must stay low for n cycles
    task quiet(input int n);
        repeat (n) begin
            @(posedge core_clk);
            #1;
            chk("grant", 16'h0000, {15'h0000, irqGrant});
        end
    endtask

    // bounded wait for the grant level; expiry ends the run
    task await_grant(input logic v, input int lim);
        int k;
        for (k = 0; k < lim; k++) begin
            @(posedge core_clk);
            #1;
            if (irqGrant === v) break;
        end
        chk("grant", {15'h0000, v}, {15'h0000, irqGrant});
        if (k == lim) complete_run();
    endtask

    // reset values and the unmapped hole
    task t_reset;
        rdchk("operand", `IXE_OFS_OPERAND, 16'h0000);
        rdchk("pc", `IXE_OFS_PC, 16'h0000);
        rdchk("flags", `IXE_OFS_FLAGS, 16'h0000);
        rdchk("status", `IXE_OFS_STATUS, 16'h0000);
        wr(4'hf, 16'hbeef);
        rdchk("unmapped", 4'hf, 16'h0000);
    endtask

    // every arithmetic op at its flag boundaries, word and byte
    task t_alu;
        run_alu(OP_SUB2, 1'b0, 16'h0002, 16'h0000, 16'h0003);
        run_alu(OP_SUB2, 1'b0, 16'h0001, 16'hffff, 16'h0004);
        run_alu(OP_SUB2, 1'b0, 16'h0000, 16'hfffe, 16'h0004);
        run_alu(OP_SUB2, 1'b0, 16'h8001, 16'h7fff, 16'h0101);
        run_alu(OP_SUB2, 1'b0, 16'h8000, 16'h7ffe, 16'h0101);
        run_alu(OP_SUB2, 1'b1, 16'hff02, 16'h0000, 16'h0003);
        run_alu(OP_SUB2, 1'b1, 16'h0081, 16'h007f, 16'h0101);
        run_alu(OP_SUB2, 1'b1, 16'h0080, 16'h007e, 16'h0101);
        run_alu(OP_SUB1, 1'b0, 16'h0000, 16'hffff, 16'h0004);
        run_alu(OP_SUB1, 1'b0, 16'h8000, 16'h7fff, 16'h0101);
        run_alu(OP_SUB1, 1'b1, 16'h0080, 16'h007f, 16'h0101);
        run_alu(OP_ADD1, 1'b0, 16'hffff, 16'h0000, 16'h0003);
        run_alu(OP_ADD1, 1'b0, 16'h7fff, 16'h8000, 16'h0104);
        run_alu(OP_ADD1, 1'b1, 16'h00ff, 16'h0000, 16'h0003);
        run_alu(OP_ADD1, 1'b1, 16'h007f, 16'h0080, 16'h0104);
        run_alu(OP_ADD2, 1'b0, 16'hfffe, 16'h0000, 16'h0003);
        run_alu(OP_ADD2, 1'b0, 16'hffff, 16'h0001, 16'h0001);
        run_alu(OP_ADD2, 1'b0, 16'h7ffe, 16'h8000, 16'h0104);
        run_alu(OP_ADD2, 1'b0, 16'h7fff, 16'h8001, 16'h0104);
        run_alu(OP_ADD2, 1'b0, 16'h7ffd, 16'h7fff, 16'h0000);
        run_alu(OP_ADD2, 1'b1, 16'h00fe, 16'h0000, 16'h0003);
        run_alu(OP_ADD2, 1'b1, 16'h00ff, 16'h0001, 16'h0001);
        run_alu(OP_ADD2, 1'b1, 16'h007e, 16'h0080, 16'h0104);
        run_alu(OP_INV, 1'b0, 16'hffff, 16'h0000, 16'h0102);
        run_alu(OP_INV, 1'b0, 16'h00f0, 16'hff0f, 16'h0005);
        run_alu(OP_INV, 1'b1, 16'h00ff, 16'h0000, 16'h0102);
        run_alu(OP_INV, 1'b1, 16'h0012, 16'h00ed, 16'h0005);
    endtask

    // a second command in the execute cycle must be dropped
    task t_refuse;
        wr(`IXE_OFS_OPERAND, 16'h0005);
        @(posedge core_clk);
        busReq <= {`IXE_OFS_CMD, 16'h0003, 1'b1, 1'b0};
        @(posedge core_clk);
        busReq <= {`IXE_OFS_CMD, 16'h0003, 1'b1, 1'b0};
        @(posedge core_clk);
        busReq <= '0;
        rdchk("operand", `IXE_OFS_OPERAND, 16'h0006);
    endtask

    // mask and unmask touch only the enable bit
    task t_mask;
        wr(`IXE_OFS_FLAGS, 16'h013f);
        cmd(OP_MASK, 1'b0);
        rdchk("flags", `IXE_OFS_FLAGS, 16'h0137);
        cmd(OP_UNMASK, 1'b0);
        rdchk("flags", `IXE_OFS_FLAGS, 16'h013f);
    endtask

    // taken both ways at the offset extremes, and not taken
    task t_branch;
        run_br(1'b1, 10'h3ff, 16'h0ffe);
        run_br(1'b1, 10'h1ff, 16'h13fe);
        run_br(1'b1, 10'h200, 16'h0c00);
        run_br(1'b0, 10'h1ff, 16'h1000);
    endtask

    // pending request across unmask, one instruction, then mask
    task t_irq;
        @(posedge core_clk);
        irqReq <= 1'b1;
        wr(`IXE_OFS_FLAGS, 16'h0000);
        quiet(3);
        cmd(OP_UNMASK, 1'b0);
        quiet(4);
        cmd(OP_NONE, 1'b0);
        await_grant(1'b1, 8);
        cmd(OP_MASK, 1'b0);
        // protected code pads the mask with a no-op
        cmd(OP_NONE, 1'b0);
        quiet(3);
        // enable written directly carries no hold-off
        wr(`IXE_OFS_FLAGS, 16'h0008);
        await_grant(1'b1, 6);
        @(posedge core_clk);
        irqReq <= 1'b0;
        await_grant(1'b0, 4);
    endtask

    // reset in mid-run clears the state again
    task t_rerst;
        wr(`IXE_OFS_OPERAND, 16'h1234);
        @(posedge core_clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        sys_rst <= 1'b0;
        rdchk("operand", `IXE_OFS_OPERAND, 16'h0000);
    endtask

    // main sequence
    initial begin
        core_clk = 1'b0;
        sys_rst = 1'b1;
        busReq = '0;
        irqReq = 1'b0;
        num_errors = 0;
        checks = 0;
        repeat (8) @(posedge core_clk);
        sys_rst <= 1'b0;
        t_reset;
        t_alu;
        t_refuse;
        t_mask;
        t_branch;
        t_irq;
        t_rerst;
        complete_run;
    end
endmodule
